// >>> rtl/mcd_decode.sv
`timescale 1ns/100ps
module mcd_decode (
    input wire logic clock,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic [mcd_pkg::OP_W-1:0] instr_word,
    input wire logic [mcd_pkg::DATA_W-1:0] accumulator,
    input wire logic [mcd_pkg::PC_W-1:0] stack_head,
    input wire logic [mcd_pkg::DM_ADDR_W-1:0] dm_addr,
    input wire logic dm_we,
    input wire logic dm_re,
    input wire logic [mcd_pkg::DATA_W-1:0] dm_wdata,
    output logic instr_ready,
    output mcd_pkg::mcd_flow_t flow,
    output logic [mcd_pkg::PC_W-1:0] pc_value,
    output logic [mcd_pkg::DATA_W-1:0] int_ctrl_set_mask,
    output logic status_write,
    output logic [mcd_pkg::DATA_W-1:0] prescale_cfg,
    output logic [mcd_pkg::DATA_W-1:0] dm_rdata
);
    import mcd_pkg::*;

    mcd_state_t state_r, state_nxt;
    logic ready_r, ready_nxt;
    mcd_flow_t flow_r, flow_nxt;
    logic [PC_W-1:0] pc_r, pc_nxt;
    logic [DATA_W-1:0] set_r, set_nxt;
    logic status_r, status_nxt;
    logic take;
    logic idle_take;
    logic ret_take;
    logic opt_take;

    assign take = instr_valid && ready_r;
    assign idle_take = take && is_idle_op(instr_word);
    assign ret_take = take && is_interrupt_return_op(instr_word);
    assign opt_take = take && is_prescale_load_op(instr_word);

    // Sequencer and outputs toward PC, stack and interrupt control
    always_comb begin
        state_nxt = state_r;
        ready_nxt = ready_r;
        flow_nxt = '0;
        pc_nxt = pc_r;
        set_nxt = NO_SET_MASK;
        // None of these instructions touch the status flags
        status_nxt = 1'b0;
        case (state_r)
            ST_READY: begin
                ready_nxt = 1'b1;
                if (ret_take) begin
                    flow_nxt.stack_pop = 1'b1;
                    flow_nxt.pc_load = 1'b1;
                    pc_nxt = stack_head;
                    set_nxt = GLOB_INT_EN_SET_MASK;
                    // Second cycle flushes the fetch, no new instruction taken
                    state_nxt = ST_FLUSH;
                    ready_nxt = 1'b0;
                end else if (idle_take) begin
                    flow_nxt.idle_ack = 1'b1;
                end
            end
            ST_FLUSH: begin
                state_nxt = ST_READY;
                ready_nxt = 1'b1;
            end
            default: begin
                state_nxt = ST_READY;
                ready_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r <= ST_READY;
            ready_r <= 1'b1;
            flow_r <= '0;
            pc_r <= '0;
            set_r <= NO_SET_MASK;
            status_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ready_r <= ready_nxt;
            flow_r <= flow_nxt;
            pc_r <= pc_nxt;
            set_r <= set_nxt;
            status_r <= status_nxt;
        end
    end

    // Legacy load kept for compatibility; data-memory path is the preferred one
    mcd_prescale_reg #(
        .REG_ADDR(PRESCALE_DM_ADDR),
        .RESET_VAL(PRESCALE_RESET)
    ) u_prescale (
        .clock(clock),
        .rst(rst),
        .load_en(opt_take),
        .load_val(accumulator),
        .dm_addr(dm_addr),
        .dm_we(dm_we),
        .dm_re(dm_re),
        .dm_wdata(dm_wdata),
        .cfg(prescale_cfg),
        .dm_rdata(dm_rdata)
    );

    assign instr_ready = ready_r;
    assign flow = flow_r;
    assign pc_value = pc_r;
    assign int_ctrl_set_mask = set_r;
    assign status_write = status_r;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    logic dm_hit;
    logic cfg_wr_hit;
    logic cfg_rd_hit;
    assign dm_hit = (dm_addr == PRESCALE_DM_ADDR);
    assign cfg_wr_hit = dm_we && dm_hit;
    assign cfg_rd_hit = dm_re && dm_hit;

    sequence ret_issue_s;
        ret_take;
    endsequence

    sequence ret_effect_s;
        flow.stack_pop && flow.pc_load && int_ctrl_set_mask == GLOB_INT_EN_SET_MASK
            && !instr_ready;
    endsequence

    sequence ret_resume_s;
        !flow.stack_pop && int_ctrl_set_mask == NO_SET_MASK && instr_ready;
    endsequence

    // Dead cycle of interrupt return: nothing issued, taking resumes next
    sequence flush_quiet_s;
        flow == '0 && int_ctrl_set_mask == NO_SET_MASK && instr_ready;
    endsequence

    idle_no_effect_a: assert property (
        idle_take |=> flow.idle_ack && !flow.stack_pop && !flow.pc_load
            && int_ctrl_set_mask == NO_SET_MASK && instr_ready
            && ($stable(prescale_cfg) || $past(cfg_wr_hit)) && !status_write
    ) else $error("idle operation changed state");

    idle_cause_a: assert property (
        flow.idle_ack |-> $past(idle_take)
    ) else $error("idle acknowledge without idle operation");

    ret_pc_load_a: assert property (
        ret_take |=> flow.pc_load && pc_value == $past(stack_head)
    ) else $error("interrupt return did not load stack head");

    pop_cause_a: assert property (
        flow.stack_pop |-> $past(ret_take)
    ) else $error("stack pop without interrupt return");

    pc_hold_a: assert property (
        !ret_take |=> $stable(pc_value)
    ) else $error("program counter value moved without return");

    ret_int_enable_a: assert property (
        ret_take |=> int_ctrl_set_mask[GLOB_INT_EN_BIT] ##1 !int_ctrl_set_mask[GLOB_INT_EN_BIT]
    ) else $error("global interrupt enable not set once");

    enable_cause_a: assert property (
        int_ctrl_set_mask != NO_SET_MASK |-> $past(ret_take)
    ) else $error("interrupt enable set without return");

    ret_two_cycle_a: assert property (
        ret_issue_s |=> ret_effect_s ##1 ret_resume_s
    ) else $error("interrupt return not two cycles");

    flush_refuse_a: assert property (
        !instr_ready |=> flush_quiet_s
    ) else $error("instruction taken in return dead cycle");

    flush_load_a: assert property (
        !instr_ready && instr_valid && instr_word == OPTLD_CODE && !cfg_wr_hit
            |=> $stable(prescale_cfg)
    ) else $error("load taken during return dead cycle");

    ready_hold_a: assert property (
        instr_ready && !ret_take |=> instr_ready
    ) else $error("ready dropped without interrupt return");

    no_status_a: assert property (
        !status_write
    ) else $error("status flags written");

    prescale_load_a: assert property (
        opt_take |=> prescale_cfg == $past(accumulator) && instr_ready && !flow.pc_load
    ) else $error("legacy load did not copy accumulator");

    load_quiet_a: assert property (
        opt_take |=> flow == '0 && int_ctrl_set_mask == NO_SET_MASK
    ) else $error("legacy load disturbed flow or interrupts");

    legacy_decode_a: assert property (
        instr_valid && instr_ready && instr_word == OPTLD_CODE
            |=> prescale_cfg == $past(accumulator)
    ) else $error("legacy load not decoded");

    dm_write_a: assert property (
        cfg_wr_hit && !opt_take |=> prescale_cfg == $past(dm_wdata)
    ) else $error("data-memory write missed prescale config");

    dm_read_a: assert property (
        cfg_rd_hit |=> dm_rdata == $past(prescale_cfg)
    ) else $error("data-memory read returned wrong value");

    cfg_hold_a: assert property (
        !opt_take && !cfg_wr_hit |=> $stable(prescale_cfg)
    ) else $error("prescale config changed without a write");

    rdata_hold_a: assert property (
        !cfg_rd_hit |=> $stable(dm_rdata)
    ) else $error("read data changed without a read");
endmodule : mcd_decode

// >>> rtl/mcd_pkg.sv
package mcd_pkg;
    localparam int OP_W = 14;
    localparam int DATA_W = 8;
    localparam int PC_W = 13;
    localparam int DM_ADDR_W = 7;

    // Idle operation: bits 6:5 are don't-care
    localparam logic [OP_W-1:0] IDLE_MASK = 14'h3F9F;
    localparam logic [OP_W-1:0] IDLE_CODE = 14'h0000;
    localparam logic [OP_W-1:0] RETI_CODE = 14'h0009;
    localparam logic [OP_W-1:0] OPTLD_CODE = 14'h0062;

    localparam logic [DM_ADDR_W-1:0] PRESCALE_DM_ADDR = 7'h01;
    localparam logic [DATA_W-1:0] PRESCALE_RESET = 8'hFF;

    localparam int GLOB_INT_EN_BIT = 7;
    localparam logic [DATA_W-1:0] GLOB_INT_EN_SET_MASK = 8'h80;
    localparam logic [DATA_W-1:0] NO_SET_MASK = 8'h00;

    typedef enum logic [1:0] {
        ST_READY = 2'b00,
        ST_FLUSH = 2'b01
    } mcd_state_t;

    // Requests to program counter and return stack, and the idle acknowledge
    typedef struct packed {
        logic stack_pop;
        logic pc_load;
        logic idle_ack;
    } mcd_flow_t;

    function automatic logic is_idle_op(input logic [OP_W-1:0] op);
        return (op & IDLE_MASK) == IDLE_CODE;
    endfunction : is_idle_op

    function automatic logic is_interrupt_return_op(input logic [OP_W-1:0] op);
        return op == RETI_CODE;
    endfunction : is_interrupt_return_op

    function automatic logic is_prescale_load_op(input logic [OP_W-1:0] op);
        return op == OPTLD_CODE;
    endfunction : is_prescale_load_op
endpackage : mcd_pkg

// >>> rtl/mcd_prescale_reg.sv
`timescale 1ns/100ps
module mcd_prescale_reg #(
    parameter logic [mcd_pkg::DM_ADDR_W-1:0] REG_ADDR = mcd_pkg::PRESCALE_DM_ADDR,
    parameter logic [mcd_pkg::DATA_W-1:0] RESET_VAL = mcd_pkg::PRESCALE_RESET
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic load_en,
    input wire logic [mcd_pkg::DATA_W-1:0] load_val,
    input wire logic [mcd_pkg::DM_ADDR_W-1:0] dm_addr,
    input wire logic dm_we,
    input wire logic dm_re,
    input wire logic [mcd_pkg::DATA_W-1:0] dm_wdata,
    output logic [mcd_pkg::DATA_W-1:0] cfg,
    output logic [mcd_pkg::DATA_W-1:0] dm_rdata
);
    import mcd_pkg::*;

    logic [DATA_W-1:0] cfg_r, cfg_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic hit;

    always_comb begin
        hit = (dm_addr == REG_ADDR);
        cfg_nxt = cfg_r;
        rdata_nxt = rdata_r;
        // Instruction load wins over a same-cycle data-memory write
        if (load_en) begin
            cfg_nxt = load_val;
        end else if (dm_we && hit) begin
            cfg_nxt = dm_wdata;
        end
        if (dm_re && hit) begin
            rdata_nxt = cfg_r;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg_r <= RESET_VAL;
            rdata_r <= '0;
        end else begin
            cfg_r <= cfg_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign cfg = cfg_r;
    assign dm_rdata = rdata_r;
endmodule : mcd_prescale_reg

// >>> verif/tb.sv
`timescale 1ns/100ps
module tb;
    import mcd_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic instr_valid = 1'b0;
    logic [OP_W-1:0] instr_word = '0;
    logic [DATA_W-1:0] accumulator = '0;
    logic [PC_W-1:0] stack_head = '0;
    logic [DM_ADDR_W-1:0] dm_addr = '0;
    logic dm_we = 1'b0;
    logic dm_re = 1'b0;
    logic [DATA_W-1:0] dm_wdata = '0;
    logic instr_ready;
    mcd_flow_t flow;
    logic [PC_W-1:0] pc_value;
    logic [DATA_W-1:0] int_ctrl_set_mask;
    logic status_write;
    logic [DATA_W-1:0] prescale_cfg;
    logic [DATA_W-1:0] dm_rdata;
    int fails = 0;
    int check_count = 0;
    int cfg_m;
    int rd_m;
    int pc_m;
    int rdy_m;
    logic [OP_W-1:0] op_tab [6] = '{14'h0000, 14'h0020, 14'h0040, 14'h0060, 14'h0009, 14'h0062};

    mcd_decode DUT (
        .clock(clock),
        .rst(rst),
        .instr_valid(instr_valid),
        .instr_word(instr_word),
        .accumulator(accumulator),
        .stack_head(stack_head),
        .dm_addr(dm_addr),
        .dm_we(dm_we),
        .dm_re(dm_re),
        .dm_wdata(dm_wdata),
        .instr_ready(instr_ready),
        .flow(flow),
        .pc_value(pc_value),
        .int_ctrl_set_mask(int_ctrl_set_mask),
        .status_write(status_write),
        .prescale_cfg(prescale_cfg),
        .dm_rdata(dm_rdata)
    );

    initial begin
        forever #10 clock = ~clock;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic model_reset();
        cfg_m = 'hFF;
        rd_m = 0;
        pc_m = 0;
        rdy_m = 1;
    endtask : model_reset

    task automatic check_reset();
        chk(instr_ready, 1);
        chk(flow, 0);
        chk(pc_value, 0);
        chk(int_ctrl_set_mask, 0);
        chk(status_write, 0);
        chk(prescale_cfg, 'hFF);
        chk(dm_rdata, 0);
    endtask : check_reset

    // One instruction cycle with random operands; the model predicts every output
    task automatic step(input logic v, input logic [OP_W-1:0] w);
        int taken;
        int pop;
        logic [DATA_W-1:0] a;
        logic [DATA_W-1:0] d;
        logic [PC_W-1:0] s;
        logic [DM_ADDR_W-1:0] ad;
        logic we;
        logic re;
        a = 8'($urandom);
        d = 8'($urandom);
        s = 13'($urandom);
        ad = ($urandom % 2) ? PRESCALE_DM_ADDR : 7'($urandom);
        we = 1'($urandom);
        re = 1'($urandom);
        @(negedge clock);
        instr_valid = v;
        instr_word = w;
        accumulator = a;
        stack_head = s;
        dm_addr = ad;
        dm_we = we;
        dm_re = re;
        dm_wdata = d;
        taken = v && rdy_m;
        pop = taken && w == 14'h0009;
        if (re && ad == PRESCALE_DM_ADDR) rd_m = cfg_m;
        if (taken && w == 14'h0062) cfg_m = a;
        else if (we && ad == PRESCALE_DM_ADDR) cfg_m = d;
        if (pop) pc_m = s;
        rdy_m = !pop;
        @(posedge clock);
        #1;
        chk(flow.idle_ack, taken && (w & 14'h3F9F) == 14'h0000);
        chk(flow.stack_pop, pop);
        chk(flow.pc_load, pop);
        chk(pc_value, pc_m);
        chk(int_ctrl_set_mask, pop ? 8'h80 : 8'h00);
        chk(instr_ready, rdy_m);
        chk(status_write, 0);
        chk(prescale_cfg, cfg_m);
        chk(dm_rdata, rd_m);
    endtask : step

    task automatic run_random(input int n);
        for (int i = 0; i < n; i++) begin
            step($urandom % 4 != 0, ($urandom % 3 == 0) ? 14'($urandom) : op_tab[$urandom % 6]);
        end
    endtask : run_random

    initial begin
        void'($urandom(23421));
        model_reset();
        repeat (2) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        check_reset();
        // Returns back to back hit the dead cycle, then two loads in a row
        step(1'b1, 14'h0009);
        step(1'b1, 14'h0009);
        step(1'b1, 14'h0009);
        step(1'b1, 14'h0062);
        step(1'b1, 14'h0062);
        foreach (op_tab[i]) step(1'b1, op_tab[i]);
        run_random(400);
        @(negedge clock);
        rst = 1'b1;
        instr_valid = 1'b0;
        dm_we = 1'b0;
        dm_re = 1'b0;
        #1;
        check_reset();
        model_reset();
        @(negedge clock);
        rst = 1'b0;
        run_random(100);
        end_of_test();
    end

    initial begin
        #100000;
        fails++;
        end_of_test();
    end
endmodule : tb
